// ==== verilog/ddr2_init_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - load extended mode register 3 only with banks idle, then wait tMRD
// - mode loads drive zero on BA2 and on address bits above A12
// - hold ODT low; once CKE is raised keep it high
// - only NOP for 200 us after start, then raise CKE
// - wait 400 ns after CKE high, then precharge all
// - load extended mode register 2 with self-refresh rate bit, rest zero
// - load extended mode register 3 with all bits zero
// - enable the DLL through the extended mode register, other bits zero
// - reset the DLL through the mode register with A8 high
// - report ready only 200 cycles after the DLL reset
// - after DLL reset precharge all then at least two refreshes
// - load the mode register with A8 low and operating settings
// - load extended mode register with calibration bits all one
// - load extended mode register again with calibration bits all zero
// - A10 high marks precharge all; bank address selects the mode register
// - a bank row is activated before any read or write
// - read or write allowed only tRCD cycles, rounded up, after activate
// - activate a bank only when closed and tRC after its last activate
// - successive activates to any banks spaced by tRRD
// - at most four activates in any tFAW window
module ddr2_init_ctrl #(
  parameter int unsigned PWR_WAIT = ddr2_init_pkg::PWR_WAIT_CYC,
  parameter int unsigned REF_COUNT = ddr2_init_pkg::REF_COUNT
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output ddr2_init_pkg::pins_t DDR_PINS
);

  // ==========================================================
  // state
  typedef struct packed {
    ddr2_init_pkg::seq_t st;
    logic [19:0] cnt;
    logic [7:0] dll_cnt;
    logic [3:0] ref_cnt;
    logic done;
    logic err;
    ddr2_init_pkg::pins_t pin;
    logic [12:0] mr_cfg;
    logic [12:0] emr_cfg;
    logic srt;
    logic pend;
    logic pend_pre;
    logic [2:0] pend_bank;
    logic [13:0] pend_row;
    logic [7:0] open;
    logic [7:0][7:0] trc;
    logic [7:0][7:0] rcd;
    logic [7:0] rrd;
    logic [3:0][7:0] faw;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic [31:0] rd;
  logic rd_hit;
  logic [31:0] wmask;
  logic wr_hit;
  logic [2:0] b;
  logic err_evt;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    rd = 32'h0000_0000;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    wmask = lane_mask(s_r.wstrb);
    b = s_r.pend_bank;
    err_evt = 1'b0;
    // default bus is NOP, ODT off
    s_nxt.pin.cmd = ddr2_init_pkg::CMD_NOP;
    s_nxt.pin.ba = 3'h0;
    s_nxt.pin.addr = 14'h0000;
    s_nxt.pin.odt = 1'b0;
    // timers count down to zero
    if (s_r.cnt != 20'h00000) s_nxt.cnt = s_r.cnt - 20'h00001;
    if (s_r.dll_cnt != 8'h00) s_nxt.dll_cnt = s_r.dll_cnt - 8'h01;
    if (s_r.rrd != 8'h00) s_nxt.rrd = s_r.rrd - 8'h01;
    for (int i = 0; i < 8; i++) begin
      if (s_r.trc[i] != 8'h00) s_nxt.trc[i] = s_r.trc[i] - 8'h01;
      if (s_r.rcd[i] != 8'h00) s_nxt.rcd[i] = s_r.rcd[i] - 8'h01;
    end
    for (int i = 0; i < 4; i++) begin
      if (s_r.faw[i] != 8'h00) s_nxt.faw[i] = s_r.faw[i] - 8'h01;
    end

    // init sequencer: each step waits its gap, issues, loads next gap
    unique case (s_r.st)
      ddr2_init_pkg::S_IDLE: begin
        s_nxt.pin.cke = 1'b0;
      end
      ddr2_init_pkg::S_PWR: if (s_r.cnt == 20'h00000) begin
        s_nxt.pin.cke = 1'b1;
        s_nxt.cnt = 20'(ddr2_init_pkg::CKE_WAIT_CYC - 1);
        s_nxt.st = ddr2_init_pkg::S_PREA1;
      end
      ddr2_init_pkg::S_CKE_WAIT: s_nxt.st = ddr2_init_pkg::S_PREA1;
      ddr2_init_pkg::S_PREA1, ddr2_init_pkg::S_PREA2: if (s_r.cnt == 20'h00000) begin
        s_nxt.pin.cmd = ddr2_init_pkg::CMD_PRE;
        s_nxt.pin.addr[ddr2_init_pkg::A_PREALL] = 1'b1;
        s_nxt.cnt = 20'(ddr2_init_pkg::RP_CYC - 1);
        s_nxt.st = (s_r.st == ddr2_init_pkg::S_PREA1) ? ddr2_init_pkg::S_EMR2
                                                      : ddr2_init_pkg::S_REFR;
      end
      ddr2_init_pkg::S_REFR: if (s_r.cnt == 20'h00000) begin
        s_nxt.pin.cmd = ddr2_init_pkg::CMD_REF;
        s_nxt.cnt = 20'(ddr2_init_pkg::RFC_CYC - 1);
        s_nxt.ref_cnt = s_r.ref_cnt + 4'h1;
        if (s_r.ref_cnt == 4'(REF_COUNT - 1)) s_nxt.st = ddr2_init_pkg::S_MR_OP;
      end
      ddr2_init_pkg::S_EMR2, ddr2_init_pkg::S_EMR3, ddr2_init_pkg::S_EMR_DLL,
      ddr2_init_pkg::S_MR_DLLRST, ddr2_init_pkg::S_MR_OP, ddr2_init_pkg::S_EMR_OCD,
      ddr2_init_pkg::S_EMR_OCDX: if (s_r.cnt == 20'h00000) begin
        // mode loads keep BA2 and A13 at zero
        s_nxt.pin.cmd = ddr2_init_pkg::CMD_LM;
        s_nxt.cnt = 20'(ddr2_init_pkg::MRD_CYC - 1);
        s_nxt.st = ddr2_init_pkg::seq_t'(s_r.st + 4'h1);
        unique case (s_r.st)
          ddr2_init_pkg::S_EMR2: begin
            s_nxt.pin.ba = ddr2_init_pkg::BA_EMR2;
            s_nxt.pin.addr[ddr2_init_pkg::A_SRT] = s_r.srt;
          end
          ddr2_init_pkg::S_EMR3: s_nxt.pin.ba = ddr2_init_pkg::BA_EMR3;
          ddr2_init_pkg::S_EMR_DLL: s_nxt.pin.ba = ddr2_init_pkg::BA_EMR;
          ddr2_init_pkg::S_MR_DLLRST: begin
            s_nxt.pin.ba = ddr2_init_pkg::BA_MR;
            s_nxt.pin.addr[ddr2_init_pkg::A_DLLRST] = 1'b1;
            s_nxt.dll_cnt = 8'(ddr2_init_pkg::DLL_LOCK_CYC);
          end
          ddr2_init_pkg::S_MR_OP: begin
            s_nxt.pin.ba = ddr2_init_pkg::BA_MR;
            s_nxt.pin.addr = {1'b0, s_r.mr_cfg};
            s_nxt.pin.addr[ddr2_init_pkg::A_DLLRST] = 1'b0;
          end
          default: begin
            // calibration default then exit, DLL kept enabled
            s_nxt.pin.ba = ddr2_init_pkg::BA_EMR;
            s_nxt.pin.addr = {1'b0, s_r.emr_cfg};
            s_nxt.pin.addr[ddr2_init_pkg::A_DLLDIS] = 1'b0;
            s_nxt.pin.addr[ddr2_init_pkg::A_OCD_LSB +: 3] =
              (s_r.st == ddr2_init_pkg::S_EMR_OCD) ? 3'h7 : 3'h0;
          end
        endcase
      end
      ddr2_init_pkg::S_DLL_WAIT: if (s_r.cnt == 20'h00000 && s_r.dll_cnt == 8'h00) begin
        s_nxt.done = 1'b1;
        s_nxt.st = ddr2_init_pkg::S_READY;
      end
      ddr2_init_pkg::S_READY: if (s_r.pend) begin
        s_nxt.pend = 1'b0;
        if (s_r.pend_pre) begin
          // precharge closes the row; tRP gates the next activate
          if (s_r.open[b]) begin
            s_nxt.pin.cmd = ddr2_init_pkg::CMD_PRE;
            s_nxt.pin.ba = b;
            s_nxt.open[b] = 1'b0;
            s_nxt.rcd[b] = 8'h00;
            if (s_nxt.trc[b] < 8'(ddr2_init_pkg::RP_CYC - 1))
              s_nxt.trc[b] = 8'(ddr2_init_pkg::RP_CYC - 1);
          end else begin
            s_nxt.err = 1'b1;
            err_evt = 1'b1;
          end
        end else if (s_r.open[b]) begin
          s_nxt.err = 1'b1;
          err_evt = 1'b1;
        end else if (s_r.trc[b] != 8'h00 || s_r.rrd != 8'h00 || s_r.faw[3] != 8'h00) begin
          s_nxt.pend = 1'b1;
        end else begin
          s_nxt.pin.cmd = ddr2_init_pkg::CMD_ACT;
          s_nxt.pin.ba = b;
          s_nxt.pin.addr = s_r.pend_row;
          s_nxt.open[b] = 1'b1;
          s_nxt.trc[b] = 8'(ddr2_init_pkg::RC_CYC - 1);
          s_nxt.rcd[b] = 8'(ddr2_init_pkg::RCD_CYC - 1);
          s_nxt.rrd = 8'(ddr2_init_pkg::RRD_CYC - 1);
          s_nxt.faw = {s_nxt.faw[2:0], 8'(ddr2_init_pkg::FAW_CYC - 1)};
        end
      end
      default: s_nxt.st = ddr2_init_pkg::S_IDLE;
    endcase

    // ==========================================================
    // register read decode
    unique case ({S_AXI_ARADDR[7:2], 2'b00})
      ddr2_init_pkg::OFF_CTRL: rd_hit = 1'b1;
      ddr2_init_pkg::OFF_STATUS: begin
        rd_hit = 1'b1;
        rd[ddr2_init_pkg::ST_DONE] = s_r.done;
        rd[ddr2_init_pkg::ST_BUSY] = (s_r.st != ddr2_init_pkg::S_IDLE) && !s_r.done;
        rd[ddr2_init_pkg::ST_PEND] = s_r.pend;
        rd[ddr2_init_pkg::ST_ERR] = s_r.err;
        rd[ddr2_init_pkg::ST_OPEN_LSB +: 8] = s_r.open;
        for (int i = 0; i < 8; i++) begin
          rd[ddr2_init_pkg::ST_RWOK_LSB + i] = s_r.open[i] && (s_r.rcd[i] == 8'h00);
        end
      end
      ddr2_init_pkg::OFF_MR_CFG: begin
        rd_hit = 1'b1;
        rd[12:0] = s_r.mr_cfg;
      end
      ddr2_init_pkg::OFF_EMR_CFG: begin
        rd_hit = 1'b1;
        rd[12:0] = s_r.emr_cfg;
      end
      ddr2_init_pkg::OFF_EMR2_CFG: begin
        rd_hit = 1'b1;
        rd[ddr2_init_pkg::A_SRT] = s_r.srt;
      end
      ddr2_init_pkg::OFF_ROW_CMD: begin
        rd_hit = 1'b1;
        rd[ddr2_init_pkg::ROW_PRE] = s_r.pend_pre;
        rd[ddr2_init_pkg::ROW_BANK_LSB +: 3] = s_r.pend_bank;
        rd[13:0] = s_r.pend_row;
      end
      default: rd_hit = 1'b0;
    endcase

    // ==========================================================
    // AXI4-Lite: address and data taken in either order
    if (s_r.awready && S_AXI_AWVALID) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = S_AXI_AWADDR;
    end
    if (s_r.wready && S_AXI_WVALID) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstrb = S_AXI_WSTRB;
    end
    if (s_r.bvalid && S_AXI_BREADY) s_nxt.bvalid = 1'b0;
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      wr_hit = 1'b1;
      unique case ({s_r.awaddr[7:2], 2'b00})
        ddr2_init_pkg::OFF_CTRL: begin
          if (wmask[ddr2_init_pkg::CTRL_START] && s_r.wdata[ddr2_init_pkg::CTRL_START]
              && s_r.st == ddr2_init_pkg::S_IDLE) begin
            s_nxt.st = ddr2_init_pkg::S_PWR;
            s_nxt.cnt = 20'(PWR_WAIT - 1);
          end
          // error clear loses to a refusal in the same cycle
          if (wmask[ddr2_init_pkg::CTRL_ERRCLR] && s_r.wdata[ddr2_init_pkg::CTRL_ERRCLR]
              && !err_evt)
            s_nxt.err = 1'b0;
        end
        ddr2_init_pkg::OFF_STATUS: ;
        ddr2_init_pkg::OFF_MR_CFG:
          s_nxt.mr_cfg = 13'(({19'h00000, s_r.mr_cfg} & ~wmask) | (s_r.wdata & wmask));
        ddr2_init_pkg::OFF_EMR_CFG:
          s_nxt.emr_cfg = 13'(({19'h00000, s_r.emr_cfg} & ~wmask) | (s_r.wdata & wmask));
        ddr2_init_pkg::OFF_EMR2_CFG:
          if (wmask[ddr2_init_pkg::A_SRT]) s_nxt.srt = s_r.wdata[ddr2_init_pkg::A_SRT];
        ddr2_init_pkg::OFF_ROW_CMD: begin
          // taken only when ready and idle, otherwise flagged
          if (s_r.st == ddr2_init_pkg::S_READY && !s_r.pend && s_r.wstrb != 4'h0) begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_pre = s_r.wdata[ddr2_init_pkg::ROW_PRE];
            s_nxt.pend_bank = s_r.wdata[ddr2_init_pkg::ROW_BANK_LSB +: 3];
            s_nxt.pend_row = s_r.wdata[13:0];
          end else begin
            s_nxt.err = 1'b1;
          end
        end
        default: wr_hit = 1'b0;
      endcase
      s_nxt.bresp = wr_hit ? ddr2_init_pkg::RESP_OKAY : ddr2_init_pkg::RESP_SLVERR;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;

    // read answered one cycle after the address is taken
    if (s_r.rvalid && S_AXI_RREADY) s_nxt.rvalid = 1'b0;
    if (s_r.arready && S_AXI_ARVALID) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd;
      s_nxt.rresp = rd_hit ? ddr2_init_pkg::RESP_OKAY : ddr2_init_pkg::RESP_SLVERR;
    end
    s_nxt.arready = !s_nxt.rvalid;
  end

  // ==========================================================
  // state register
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_r <= '0;
      s_r.pin.cmd <= ddr2_init_pkg::CMD_NOP;
      s_r.mr_cfg <= ddr2_init_pkg::MR_CFG_RST;
      s_r.emr_cfg <= ddr2_init_pkg::EMR_CFG_RST;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign DDR_PINS = s_r.pin;
  assign S_AXI_AWREADY = s_r.awready;
  assign S_AXI_WREADY = s_r.wready;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = s_r.arready;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;

  // ==========================================================
  // checks
  logic [19:0] h_low;
  logic [7:0] h_cke;
  logic [7:0] h_dll;
  logic [7:0] h_gap;
  logic is_lm;

  assign is_lm = s_r.pin.cmd == ddr2_init_pkg::CMD_LM;

  // elapsed-cycle helpers for the checks
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      h_low <= 20'h00000;
      h_cke <= 8'h00;
      h_dll <= 8'h00;
      h_gap <= 8'hFF;
    end else if (CE) begin
      if (s_r.st != ddr2_init_pkg::S_IDLE && !s_r.pin.cke && h_low != 20'hFFFFF)
        h_low <= h_low + 20'h00001;
      if (s_r.pin.cke && h_cke != 8'hFF) h_cke <= h_cke + 8'h01;
      if (is_lm && s_r.pin.ba == ddr2_init_pkg::BA_MR && s_r.pin.addr[ddr2_init_pkg::A_DLLRST])
        h_dll <= 8'h00;
      else if (h_dll != 8'hFF)
        h_dll <= h_dll + 8'h01;
      if (s_r.pin.cmd == ddr2_init_pkg::CMD_ACT) h_gap <= 8'h01;
      else if (h_gap != 8'hFF) h_gap <= h_gap + 8'h01;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_lm_load;
    (CE && is_lm) ##1 CE;
  endsequence

  property p_odt_off;
    !s_r.pin.odt;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("odt driven high");

  property p_cke_hold;
    s_r.pin.cke |=> s_r.pin.cke;
  endproperty
  a_cke_hold: assert property (p_cke_hold) else $error("cke dropped");

  property p_pwr_wait;
    $rose(s_r.pin.cke) |-> h_low >= 20'(PWR_WAIT);
  endproperty
  a_pwr_wait: assert property (p_pwr_wait) else $error("cke raised early");

  property p_first_prea;
    (s_r.pin.cmd == ddr2_init_pkg::CMD_PRE && s_r.st == ddr2_init_pkg::S_EMR2)
      |-> s_r.pin.addr[ddr2_init_pkg::A_PREALL] && h_cke >= 8'(ddr2_init_pkg::CKE_WAIT_CYC);
  endproperty
  a_first_prea: assert property (p_first_prea) else $error("precharge all too early");

  property p_emr2_code;
    (is_lm && s_r.pin.ba == ddr2_init_pkg::BA_EMR2)
      |-> s_r.pin.addr == (14'(s_r.srt) << ddr2_init_pkg::A_SRT);
  endproperty
  a_emr2_code: assert property (p_emr2_code) else $error("bad emr2 code");

  property p_emr3_code;
    (is_lm && s_r.pin.ba[1:0] == 2'h3) |-> s_r.pin.ba[2] == 1'b0 && s_r.pin.addr == 14'h0000;
  endproperty
  a_emr3_code: assert property (p_emr3_code) else $error("bad emr3 code");

  property p_dllrst_code;
    (is_lm && s_r.pin.ba == ddr2_init_pkg::BA_MR && !s_r.done && s_r.st == ddr2_init_pkg::S_PREA2)
      |-> s_r.pin.addr == 14'h0100;
  endproperty
  a_dllrst_code: assert property (p_dllrst_code) else $error("bad dll reset code");

  property p_dll_lock;
    $rose(s_r.done) |-> h_dll >= 8'(ddr2_init_pkg::DLL_LOCK_CYC);
  endproperty
  a_dll_lock: assert property (p_dll_lock) else $error("ready before dll lock");

  property p_mrd_gap;
    s_lm_load |-> s_r.pin.cmd == ddr2_init_pkg::CMD_NOP;
  endproperty
  a_mrd_gap: assert property (p_mrd_gap) else $error("command inside tMRD");

  property p_rrd_gap;
    s_r.pin.cmd == ddr2_init_pkg::CMD_ACT |-> h_gap >= 8'(ddr2_init_pkg::RRD_CYC);
  endproperty
  a_rrd_gap: assert property (p_rrd_gap) else $error("activates closer than tRRD");

endmodule : ddr2_init_ctrl

// ==== verilog/ddr2_init_pkg.sv ====
package ddr2_init_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // minimum times round up to whole clock cycles
  function automatic int unsigned ns_to_cyc(input int unsigned t_ns);
    return (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : ns_to_cyc
  localparam int unsigned T_PWR_US = 200;
  localparam int unsigned PWR_WAIT_CYC = (T_PWR_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned T_CKE_NS = 400;
  localparam int unsigned CKE_WAIT_CYC = ns_to_cyc(T_CKE_NS);
  localparam int unsigned MRD_CYC = 2;
  localparam int unsigned T_RP_NS = 15;
  localparam int unsigned RP_CYC = ns_to_cyc(T_RP_NS);
  localparam int unsigned T_RFC_NS = 128;
  localparam int unsigned RFC_CYC = ns_to_cyc(T_RFC_NS);
  localparam int unsigned T_RCD_NS = 15;
  localparam int unsigned RCD_CYC = ns_to_cyc(T_RCD_NS);
  localparam int unsigned T_RC_NS = 55;
  localparam int unsigned RC_CYC = ns_to_cyc(T_RC_NS);
  localparam int unsigned T_RRD_NS = 10;
  localparam int unsigned RRD_CYC = ns_to_cyc(T_RRD_NS);
  localparam int unsigned T_FAW_NS = 50;
  localparam int unsigned FAW_CYC = ns_to_cyc(T_FAW_NS);
  localparam int unsigned DLL_LOCK_CYC = 200;
  localparam int unsigned REF_COUNT = 2;

  // ==========================================================
  // pin layout and command codes {cs_n, ras_n, cas_n, we_n}
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned BA_W = 3;
  localparam int unsigned NUM_BANKS = 8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LM = 4'h0;
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;
  localparam int unsigned A_PREALL = 10;
  localparam int unsigned A_DLLRST = 8;
  localparam int unsigned A_SRT = 7;
  localparam int unsigned A_OCD_LSB = 7;
  localparam int unsigned A_DLLDIS = 0;

  // ==========================================================
  // register map (byte offsets) and fields
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MR_CFG = 8'h08;
  localparam logic [7:0] OFF_EMR_CFG = 8'h0C;
  localparam logic [7:0] OFF_EMR2_CFG = 8'h10;
  localparam logic [7:0] OFF_ROW_CMD = 8'h14;
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_ERRCLR = 1;
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_BUSY = 1;
  localparam int unsigned ST_PEND = 2;
  localparam int unsigned ST_ERR = 3;
  localparam int unsigned ST_OPEN_LSB = 8;
  localparam int unsigned ST_RWOK_LSB = 16;
  localparam int unsigned ROW_PRE = 31;
  localparam int unsigned ROW_BANK_LSB = 16;
  localparam logic [12:0] MR_CFG_RST = 13'h0000;
  localparam logic [12:0] EMR_CFG_RST = 13'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE, S_PWR, S_CKE_WAIT, S_PREA1, S_EMR2, S_EMR3, S_EMR_DLL, S_MR_DLLRST,
    S_PREA2, S_REFR, S_MR_OP, S_EMR_OCD, S_EMR_OCDX, S_DLL_WAIT, S_READY
  } seq_t;

  typedef struct packed {
    logic cke;
    logic odt;
    logic [3:0] cmd;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } pins_t;

endpackage : ddr2_init_pkg

// ==== verification/ddr2_dev_model.sv ====
`timescale 1ns/1ps
// ==========
// memory device model: keeps mode loads, times the dll, flags bad spacing
module ddr2_dev_model (
  input wire logic clk,
  input wire logic rst,
  input wire ddr2_init_pkg::pins_t pins,
  output logic [13:0] mr_r [4],
  output logic dll_ok,
  output int n_ref,
  output int viol
);
  int cyc, lm_at, cke_at, lock, act_at;
  int acts[4];
  int last[8];
  logic up;
  // one pass per command edge
  always @(posedge clk) begin
    if (rst) begin
      cyc = 100;
      lm_at = 0;
      act_at = 0;
      cke_at = 0;
      lock = 0;
      dll_ok = 0;
      up = 0;
      n_ref = 0;
      viol = 0;
      acts = '{default: 0};
      last = '{default: 0};
      mr_r = '{default: '0};
    end else begin
      cyc++;
      if (lock > 0) begin
        lock--;
        dll_ok = (lock == 0);
      end
      if ((up && !pins.cke) || pins.odt) viol++;
      if (pins.cke && !up) cke_at = cyc;
      up |= pins.cke;
      if (pins.cmd != ddr2_init_pkg::CMD_NOP) begin
        if (!up || cyc - cke_at < ddr2_init_pkg::CKE_WAIT_CYC) viol++;
        if (cyc - lm_at < ddr2_init_pkg::MRD_CYC) viol++;
      end
      if (pins.cmd == ddr2_init_pkg::CMD_LM) begin
        lm_at = cyc;
        if (pins.ba[2] || pins.addr[13]) viol++;
        mr_r[pins.ba[1:0]] = pins.addr;
        if (pins.ba[1:0] == 2'h0 && pins.addr[8]) lock = 200;
      end
      if (pins.cmd == ddr2_init_pkg::CMD_REF) n_ref++;
      if (pins.cmd == ddr2_init_pkg::CMD_ACT) begin
        if (cyc - act_at < ddr2_init_pkg::RRD_CYC) viol++;
        if (cyc - acts[0] < ddr2_init_pkg::FAW_CYC) viol++;
        if (cyc - last[pins.ba] < ddr2_init_pkg::RC_CYC) viol++;
        acts = '{acts[1], acts[2], acts[3], cyc};
        act_at = cyc;
        last[pins.ba] = cyc;
      end
    end
  end
endmodule : ddr2_dev_model

// ==== verification/ddr2_init_ctrl_tb.sv ====
`timescale 1ns/1ps
// ==========
// bench top
module ddr2_init_ctrl_tb;
  logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, rdy = 1;
  logic ce = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic awr, wrd, bv, arr, rv, dll_ok;
  logic [1:0] bresp, rresp;
  logic [13:0] mr [4];
  ddr2_init_pkg::pins_t pins;
  int viol, n_ref, n_errors = 0, cmp_count = 0;
  ddr2_init_ctrl #(.PWR_WAIT(50), .REF_COUNT(2)) u_ddr2_init_ctrl (
    .CORE_CLK(clk), .RST(rst), .CE(ce), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(rdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rdy), .DDR_PINS(pins));
  ddr2_dev_model u_ddr2_dev_model (.clk(clk), .rst(rst), .pins(pins), .mr_r(mr),
    .dll_ok(dll_ok), .n_ref(n_ref), .viol(viol));
  // free running clock
  initial forever #2.5 clk = ~clk;
  // ==========
  // compare, verdict and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task automatic hang(input int n);
    if (n >= 500) begin
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      close_out();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv && n < 500);
    hang(n);
    chk(bresp, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] e);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
    end while (!rv && n < 500);
    hang(n);
    q = rdata;
    chk(rresp, e);
  endtask : rd
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(8'h04, 2'h0);
      n++;
    end while (q[b] !== v && n < 500);
    hang(n);
  endtask : poll
  // ==========
  // scenarios
  task automatic t_regs;
    rd(8'h08, 2'h0);
    chk(q, 32'h0);
    wr(8'h08, 32'h0742, 2'h0);
    wr(8'h0C, 32'h0385, 2'h0);
    rd(8'h08, 2'h0);
    chk(q, 32'h0742);
    rd(8'h0C, 2'h0);
    chk(q, 32'h0385);
    wr(8'h40, 32'hFFFF_FFFF, 2'h2);
    rd(8'h40, 2'h2);
    chk(q, 32'h0);
  endtask : t_regs
  task automatic t_early;
    wr(8'h14, 32'h5, 2'h0);
    rd(8'h04, 2'h0);
    chk(q[3:0], 4'h8);
    wr(8'h00, 32'h2, 2'h0);
    rd(8'h04, 2'h0);
    chk(q[3:0], 4'h0);
  endtask : t_early
  task automatic t_init;
    wr(8'h10, 32'h80, 2'h0);
    rd(8'h10, 2'h0);
    chk(q, 32'h80);
    wr(8'h00, 32'h1, 2'h0);
    chk(pins.cke, 1'b0);
    rd(8'h04, 2'h0);
    chk(q[1:0], 2'h2);
    ce <= 0;
    repeat (60) @(posedge clk);
    chk(pins.cke, 1'b0);
    ce <= 1;
    poll(0, 1'b1);
    chk(dll_ok, 1'b1);
    chk(mr[2], 14'h0080);
    chk(mr[3], 14'h0);
    chk(mr[0], 14'h0642);
    chk(mr[1], 14'h0004);
    chk(n_ref, 2);
  endtask : t_init
  task automatic row(input logic [31:0] c);
    wr(8'h14, c, 2'h0);
    poll(2, 1'b0);
  endtask : row
  task automatic t_rows;
    for (int b = 0; b < 5; b++) row({13'h0, 3'(b), 16'h5});
    repeat (4) @(posedge clk);
    rd(8'h04, 2'h0);
    chk(q[23:8], 16'h1F1F);
    row(32'h5);
    rd(8'h04, 2'h0);
    chk(q[3], 1'b1);
    row(32'h8000_0000);
    rd(8'h04, 2'h0);
    chk(q[23:8], 16'h1E1E);
    row(32'h9);
    row(32'h0005_0001);
    row(32'h8005_0000);
    row(32'h0005_0002);
    rd(8'h14, 2'h0);
    chk(q, 32'h0005_0002);
    rd(8'h04, 2'h0);
    chk(q[13], 1'b1);
    chk(viol, 0);
  endtask : t_rows
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_early();
    t_init();
    t_rows();
    close_out();
  end
endmodule : ddr2_init_ctrl_tb
